// ===== rtl/acd_pkg.sv
// Shared constants, types and helpers for the clock delay and sync registers
package acd_pkg;

    // Register indices and byte addresses (address is four times the index)
    localparam logic [3:0]  IDX_COARSE   = 4'hC;
    localparam logic [3:0]  IDX_FINE     = 4'hD;
    localparam logic [3:0]  IDX_SYNC     = 4'hE;
    localparam logic [3:0]  IDX_RSV      = 4'hF;
    localparam logic [7:0]  ADDR_COARSE  = {2'h0, IDX_COARSE, 2'h0};
    localparam logic [7:0]  ADDR_FINE    = {2'h0, IDX_FINE, 2'h0};
    localparam logic [7:0]  ADDR_SYNC    = {2'h0, IDX_SYNC, 2'h0};
    localparam logic [7:0]  ADDR_RSV     = {2'h0, IDX_RSV, 2'h0};

    // Reset values
    localparam logic [15:0] RST_COARSE   = 16'h0004;
    localparam logic [15:0] RST_FINE     = 16'h0000;
    localparam logic [15:0] RST_SYNC     = 16'h0003;
    localparam logic [15:0] RST_RSV      = 16'h000C;

    // Writable bits; reserved bits stay zero
    localparam logic [15:0] WMASK_COARSE = 16'hFFFC;
    localparam logic [15:0] WMASK_FINE   = 16'hFDFF;
    localparam logic [15:0] WMASK_SYNC   = 16'hFFDF;

    // Field positions
    localparam int CAM_LSB = 4;
    localparam int STA_BIT = 3;
    localparam int DCC_BIT = 2;
    localparam int FAM_LSB = 10;
    localparam int SA_BIT  = 8;
    localparam int LCF_LSB = 0;
    localparam int DRC_LSB = 6;
    localparam int SP_LSB  = 3;
    localparam int ES_BIT  = 2;
    localparam int DOC_BIT = 1;
    localparam int DR_BIT  = 0;

    // Delay and frequency figures
    localparam logic [11:0] COARSE_MAX_CODE = 12'h97F;    // 2431
    localparam logic [31:0] COARSE_MAX_FS   = 32'h000C96A8; // 825 ps
    localparam logic [5:0]  FINE_MAX_CODE   = 6'h3F;      // 63
    localparam logic [31:0] FINE_MAX_FS     = 32'h000008FC; // 2.3 ps
    localparam logic [9:0]  REF_MAX_CODE    = 10'h27F;    // 639
    localparam logic [31:0] REF_MAX_PS      = 32'h000003E8; // 1000 ps
    localparam logic [10:0] LC_TOP_MHZ      = 11'h5DC;    // 1.5 GHz
    localparam logic [10:0] LC_MID_MHZ      = 11'h44C;    // 1.1 GHz
    localparam logic [10:0] LC_STEP_LO      = 11'h064;
    localparam logic [10:0] LC_STEP_HI      = 11'h04B;
    localparam logic [3:0]  LC_MID_ONES     = 4'h4;
    localparam logic [8:0]  PHASE_STEP_DEG  = 9'h05A;     // 90 degrees

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } acd_axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } acd_axil_rsp_t;

    typedef struct packed {
        logic        aperture_adjust_on;
        logic [11:0] coarse_delay_code;
        logic [5:0]  fine_delay_code;
        logic [19:0] aperture_delay_fs;
        logic        lc_filter_on;
        logic [7:0]  lc_filter_tuning;
        logic [10:0] lc_center_mhz;
        logic        dcs_on;
        logic [9:0]  ref_delay_ps;
        logic [8:0]  ref_phase_deg;
        logic        slave_mode;
        logic        dclk_reset_enable;
        logic        dclk_reset;
    } acd_clk_ctrl_t;

    // Clamp a code at its ceiling
    function automatic logic [11:0] acd_sat(input logic [11:0] code,
                                           input logic [11:0] top);
        acd_sat = (code > top) ? top : code;
    endfunction

    // Linear map of a code onto a delay
    function automatic logic [31:0] acd_scale(input logic [11:0] code,
                                             input logic [11:0] top,
                                             input logic [31:0] full);
        acd_scale = ({20'h0, code} * full) / {20'h0, top};
    endfunction

    // Thermometer tuning word to LC centre frequency
    function automatic logic [10:0] acd_lc_mhz(input logic [7:0] therm);
        logic [3:0] ones;
        ones = 4'h0;
        for (int i = 0; i < 8; i++) begin
            ones = ones + {3'h0, therm[i]};
        end
        if (ones <= LC_MID_ONES) begin
            acd_lc_mhz = LC_TOP_MHZ - LC_STEP_LO * {7'h0, ones};
        end else begin
            acd_lc_mhz = LC_MID_MHZ
                         - LC_STEP_HI * {7'h0, 4'(ones - LC_MID_ONES)};
        end
    endfunction

endpackage

// ===== rtl/acd_quarter_div.sv
// Quarter-rate reference clock divider with phase latch
module acd_quarter_div (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       resync,
    input  wire logic       drive_en,
    input  wire logic [1:0] phase_sel,
    input  wire logic       ref_level,
    output logic            refclk_out_a,
    output logic            refclk_out_b,
    output logic            latched_ref
);
    import acd_pkg::*;

    typedef struct packed {
        logic [1:0] cnt;
        logic       out_a;
        logic       out_b;
        logic       latched;
    } acd_div_state_t;

    acd_div_state_t st;
    acd_div_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.cnt = resync ? 2'h0 : 2'(st.cnt + 2'h1); // R12
        next_st.out_a = drive_en & next_st.cnt[1]; // R13
        next_st.out_b = drive_en & next_st.cnt[1]; // R13
        if (st.cnt == phase_sel) begin
            next_st.latched = ref_level; // R11
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign refclk_out_a = st.out_a;
    assign refclk_out_b = st.out_b;
    assign latched_ref  = st.latched;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_div_period;
        !resync [*5] |-> st.cnt == $past(st.cnt, 4);
    endproperty
    a_div_period: assert property (p_div_period) // R13
        else $error("Divider does not repeat every four cycles");

endmodule

// ===== rtl/acd_regs.sv
// Clock delay and multi-chip sync register bank with AXI4-Lite slave
// What this block does
// R1: Coarse 12-bit code delays sample clock linearly, 0 to 825 ps at 2431.
// R2: Coarse codes 2432 and above hold the maximum delay.
// R3: Coarse delay applies only when either adjust select bit is set.
// R4: Aperture-adjust select enables both coarse and fine delay.
// R5: Stabilizer enable resets to one; zero disables the stabilizer.
// R6: Software writes zero to all reserved bits.
// R7: With adjust on, 6-bit fine code adds 0 to 2.3 ps.
// R8: Combined select enables adjust and LC filter, overriding the other.
// R9: Thermometer tuning sets LC centre: 1.5, 1.1, 0.8 GHz.
// R10: Reference delay 0 to 1000 ps at 639, saturating beyond.
// R11: Phase select chooses 0, 90, 180 or 270 degree latch.
// R12: Slave bit syncs dividers to incoming reference; clear means master.
// R13: Output disable clear drives clock/4 on both outputs; resets off.
// R14: Reset-disable resets to one; zero enables data-clock reset.
// R15: Reserved word is read-only and reads 000Ch.
// R16: Total delay is coarse plus fine; zero when adjust is off.
module acd_regs (
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    input  wire acd_pkg::acd_axil_req_t axil_req,
    output acd_pkg::acd_axil_rsp_t      axil_rsp,
    input  wire logic                   refclk_in,
    input  wire logic                   data_clock_reset_input,
    output acd_pkg::acd_clk_ctrl_t      clk_ctrl,
    output logic                        refclk_out_a,
    output logic                        refclk_out_b,
    output logic                        latched_ref
);
    import acd_pkg::*;

    typedef struct packed {
        logic [15:0]   coarse;
        logic [15:0]   fine;
        logic [15:0]   sync;
        logic          aw_held;
        logic [7:0]    aw_addr;
        logic          w_held;
        logic [31:0]   w_data;
        logic [3:0]    w_strb;
        acd_axil_rsp_t rsp;
        logic [1:0]    ref_sync;
        logic [1:0]    rst_sync;
        logic          ref_prev;
        acd_clk_ctrl_t ctrl;
    } acd_state_t;

    acd_state_t st;
    acd_state_t next_st;

    logic          aw_fire;
    logic          w_fire;
    logic          ar_fire;
    logic          adj_on;
    logic          ref_rise;
    logic [11:0]   cam;
    logic [11:0]   cam_sat;
    logic [5:0]    fam;
    logic [9:0]    drc;
    logic [9:0]    drc_sat;
    logic [1:0]    sp;
    logic [31:0]   coarse_fs;
    logic [31:0]   fine_fs;
    logic [31:0]   ref_ps;

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb,
                                          input logic [15:0] mask);
        logic [15:0] upd;
        upd = old;
        if (strb[0]) begin
            upd[7:0] = data[7:0];
        end
        if (strb[1]) begin
            upd[15:8] = data[15:8];
        end
        merge = upd & mask;
    endfunction

    assign aw_fire = axil_req.awvalid & st.rsp.awready;
    assign w_fire  = axil_req.wvalid & st.rsp.wready;
    assign ar_fire = axil_req.arvalid & st.rsp.arready;

    // Field decode
    assign cam = st.coarse[CAM_LSB +: 12];
    assign fam = st.fine[FAM_LSB +: 6];
    assign drc = st.sync[DRC_LSB +: 10];
    assign sp  = st.sync[SP_LSB +: 2];
    assign adj_on = st.fine[SA_BIT] | st.coarse[STA_BIT]; // R3 R4 R8
    assign cam_sat = acd_sat(cam, COARSE_MAX_CODE); // R2
    assign drc_sat = 10'(acd_sat({2'h0, drc}, {2'h0, REF_MAX_CODE})); // R10
    assign coarse_fs = acd_scale(cam_sat, COARSE_MAX_CODE,
                                 COARSE_MAX_FS); // R1
    assign fine_fs = acd_scale({6'h0, fam}, {6'h0, FINE_MAX_CODE},
                               FINE_MAX_FS); // R7
    assign ref_ps = acd_scale({2'h0, drc_sat}, {2'h0, REF_MAX_CODE},
                              REF_MAX_PS); // R10
    assign ref_rise = st.ref_sync[1] & ~st.ref_prev;

    always_comb begin
        next_st = st;

        // Pin synchronisers
        next_st.ref_sync = {st.ref_sync[0], refclk_in};
        next_st.rst_sync = {st.rst_sync[0], data_clock_reset_input};
        next_st.ref_prev = st.ref_sync[1];

        // Write address and data, taken in either order
        if (aw_fire) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = axil_req.awaddr;
        end
        if (w_fire) begin
            next_st.w_held = 1'b1;
            next_st.w_data = axil_req.wdata;
            next_st.w_strb = axil_req.wstrb;
        end
        if (st.rsp.bvalid && axil_req.bready) begin
            next_st.rsp.bvalid = 1'b0;
        end
        if (st.aw_held && st.w_held && !st.rsp.bvalid) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.rsp.bvalid = 1'b1;
            next_st.rsp.bresp = RESP_OKAY;
            case (st.aw_addr)
                ADDR_COARSE: begin
                    next_st.coarse = merge(st.coarse, st.w_data,
                                           st.w_strb, WMASK_COARSE); // R6
                end
                ADDR_FINE: begin
                    next_st.fine = merge(st.fine, st.w_data,
                                         st.w_strb, WMASK_FINE); // R6
                end
                ADDR_SYNC: begin
                    next_st.sync = merge(st.sync, st.w_data,
                                         st.w_strb, WMASK_SYNC); // R6
                end
                ADDR_RSV: begin
                    next_st.rsp.bresp = RESP_OKAY; // R15
                end
                default: begin
                    next_st.rsp.bresp = RESP_SLVERR;
                end
            endcase
        end
        next_st.rsp.awready = !next_st.aw_held && !next_st.rsp.bvalid;
        next_st.rsp.wready  = !next_st.w_held && !next_st.rsp.bvalid;

        // Read channel
        if (st.rsp.rvalid && axil_req.rready) begin
            next_st.rsp.rvalid = 1'b0;
        end
        if (ar_fire) begin
            next_st.rsp.rvalid = 1'b1;
            next_st.rsp.rresp = RESP_OKAY;
            case (axil_req.araddr)
                ADDR_COARSE: begin
                    next_st.rsp.rdata = {16'h0, st.coarse};
                end
                ADDR_FINE: begin
                    next_st.rsp.rdata = {16'h0, st.fine};
                end
                ADDR_SYNC: begin
                    next_st.rsp.rdata = {16'h0, st.sync};
                end
                ADDR_RSV: begin
                    next_st.rsp.rdata = {16'h0, RST_RSV}; // R15
                end
                default: begin
                    next_st.rsp.rdata = 32'h0;
                    next_st.rsp.rresp = RESP_SLVERR;
                end
            endcase
        end
        next_st.rsp.arready = !next_st.rsp.rvalid;

        // Clock path controls
        next_st.ctrl.aperture_adjust_on = adj_on; // R4
        next_st.ctrl.coarse_delay_code = adj_on ? cam_sat : 12'h0; // R3
        next_st.ctrl.fine_delay_code = adj_on ? fam : 6'h0; // R7
        next_st.ctrl.aperture_delay_fs = adj_on
            ? 20'(coarse_fs + fine_fs) : 20'h0; // R16
        next_st.ctrl.lc_filter_on = st.fine[SA_BIT]; // R8
        next_st.ctrl.lc_filter_tuning = st.fine[LCF_LSB +: 8]; // R9
        next_st.ctrl.lc_center_mhz =
            acd_lc_mhz(st.fine[LCF_LSB +: 8]); // R9
        next_st.ctrl.dcs_on = st.coarse[DCC_BIT]; // R5
        next_st.ctrl.ref_delay_ps = 10'(ref_ps); // R10
        next_st.ctrl.ref_phase_deg = 9'({7'h0, sp} * PHASE_STEP_DEG); // R11
        next_st.ctrl.slave_mode = st.sync[ES_BIT]; // R12
        next_st.ctrl.dclk_reset_enable = !st.sync[DR_BIT]; // R14
        next_st.ctrl.dclk_reset =
            !st.sync[DR_BIT] && st.rst_sync[1]; // R14
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st <= '0;
            st.coarse <= RST_COARSE; // R5
            st.fine <= RST_FINE;
            st.sync <= RST_SYNC; // R13 R14
            st.rsp.awready <= 1'b1;
            st.rsp.wready <= 1'b1;
            st.rsp.arready <= 1'b1;
            st.ctrl.dcs_on <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    acd_quarter_div u_div (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .resync       (st.sync[ES_BIT] & ref_rise), // R12
        .drive_en     (!st.sync[DOC_BIT]), // R13
        .phase_sel    (sp),
        .ref_level    (st.ref_sync[1]),
        .refclk_out_a (refclk_out_a),
        .refclk_out_b (refclk_out_b),
        .latched_ref  (latched_ref)
    );

    assign axil_rsp = st.rsp;
    assign clk_ctrl = st.ctrl;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_wr_commit(logic [7:0] a);
        st.aw_held && st.w_held && !st.rsp.bvalid && st.aw_addr == a;
    endsequence

    sequence s_rd_take(logic [7:0] a);
        ar_fire && axil_req.araddr == a;
    endsequence

    property p_rsv_read;
        s_rd_take(ADDR_RSV) |=> st.rsp.rvalid
            && st.rsp.rdata == {16'h0, RST_RSV};
    endproperty
    a_rsv_read: assert property (p_rsv_read) // R15
        else $error("Reserved word read wrong value");

    property p_rsv_const;
        s_wr_commit(ADDR_RSV) |=> st.rsp.bvalid
            && $stable(st.coarse) && $stable(st.sync);
    endproperty
    a_rsv_const: assert property (p_rsv_const) // R15
        else $error("Reserved word write disturbed state");

    property p_coarse_write;
        s_wr_commit(ADDR_COARSE) |=> st.coarse ==
            merge($past(st.coarse), $past(st.w_data),
                  $past(st.w_strb), WMASK_COARSE) ##1
            st.ctrl.coarse_delay_code ==
            (adj_on ? acd_sat(cam, COARSE_MAX_CODE) : 12'h0);
    endproperty
    a_coarse_write: assert property (p_coarse_write) // R1
        else $error("Coarse write did not reach delay code");

    property p_coarse_sat;
        adj_on && cam > COARSE_MAX_CODE |=>
            st.ctrl.coarse_delay_code == COARSE_MAX_CODE
            && st.ctrl.aperture_delay_fs >= 20'(COARSE_MAX_FS);
    endproperty
    a_coarse_sat: assert property (p_coarse_sat) // R2
        else $error("Coarse delay not held at maximum");

    property p_adjust_off;
        !st.fine[SA_BIT] && !st.coarse[STA_BIT] |=>
            st.ctrl.aperture_delay_fs == 20'h0
            && st.ctrl.coarse_delay_code == 12'h0
            && !st.ctrl.aperture_adjust_on;
    endproperty
    a_adjust_off: assert property (p_adjust_off) // R3
        else $error("Delay applied with adjust off");

    property p_fine;
        adj_on |=> st.ctrl.fine_delay_code == $past(fam);
    endproperty
    a_fine: assert property (p_fine) // R7
        else $error("Fine delay code not applied");

    property p_sa_override;
        st.fine[SA_BIT] |=> st.ctrl.lc_filter_on
            && st.ctrl.aperture_adjust_on;
    endproperty
    a_sa_override: assert property (p_sa_override) // R8
        else $error("Combined select did not enable both");

    property p_dcs;
        1'b1 |=> st.ctrl.dcs_on == $past(st.coarse[DCC_BIT]);
    endproperty
    a_dcs: assert property (p_dcs) // R5
        else $error("Stabilizer enable does not follow register");

    property p_ref_sat;
        drc >= REF_MAX_CODE |=>
            st.ctrl.ref_delay_ps == 10'(REF_MAX_PS);
    endproperty
    a_ref_sat: assert property (p_ref_sat) // R10
        else $error("Reference delay not saturated");

    property p_phase;
        $stable(sp) |=> st.ctrl.ref_phase_deg ==
            9'({7'h0, $past(sp)} * PHASE_STEP_DEG);
    endproperty
    a_phase: assert property (p_phase) // R11
        else $error("Phase select decode wrong");

    property p_doc_off;
        st.sync[DOC_BIT] [*2] |-> !refclk_out_a && !refclk_out_b;
    endproperty
    a_doc_off: assert property (p_doc_off) // R13
        else $error("Reference outputs driven while disabled");

    property p_dr;
        st.sync[DR_BIT] |=> !st.ctrl.dclk_reset_enable
            && !st.ctrl.dclk_reset;
    endproperty
    a_dr: assert property (p_dr) // R14
        else $error("Data-clock reset active while disabled");

endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the clock delay and sync register bank
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import acd_pkg::*;

    logic          clk_sys;
    logic          rst;
    logic          refclk_in;
    logic          data_clock_reset_input;
    acd_axil_req_t axil_req;
    acd_axil_rsp_t axil_rsp;
    acd_clk_ctrl_t clk_ctrl;
    logic          refclk_out_a;
    logic          refclk_out_b;
    logic          latched_ref;
    int            miscompares;
    int            n_tests;

    acd_regs u_acd_regs (
        .clk_sys                (clk_sys),
        .rst                    (rst),
        .axil_req               (axil_req),
        .axil_rsp               (axil_rsp),
        .refclk_in              (refclk_in),
        .data_clock_reset_input (data_clock_reset_input),
        .clk_ctrl               (clk_ctrl),
        .refclk_out_a           (refclk_out_a),
        .refclk_out_b           (refclk_out_b),
        .latched_ref            (latched_ref)
    );

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic finish_test;
        if (miscompares == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask

    // Let a register write reach the control outputs
    task automatic settle;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        logic ta;
        logic tw;
        logic tb;
        logic [1:0] r;
        @(posedge clk_sys);
        axil_req.awvalid <= 1'b1;
        axil_req.awaddr  <= a;
        axil_req.wvalid  <= 1'b1;
        axil_req.wdata   <= d;
        axil_req.wstrb   <= 4'hF;
        axil_req.bready  <= 1'b1;
        do begin
            @(negedge clk_sys);
            ta = axil_req.awvalid && axil_rsp.awready;
            tw = axil_req.wvalid && axil_rsp.wready;
            tb = axil_rsp.bvalid;
            r  = axil_rsp.bresp;
            @(posedge clk_sys);
            if (ta) axil_req.awvalid <= 1'b0;
            if (tw) axil_req.wvalid <= 1'b0;
        end while (!tb);
        axil_req.bready <= 1'b0;
        check({30'h0, r}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        logic ta;
        logic tr;
        logic [31:0] d;
        logic [1:0]  r;
        @(posedge clk_sys);
        axil_req.arvalid <= 1'b1;
        axil_req.araddr  <= a;
        axil_req.rready  <= 1'b1;
        do begin
            @(negedge clk_sys);
            ta = axil_req.arvalid && axil_rsp.arready;
            tr = axil_rsp.rvalid;
            d  = axil_rsp.rdata;
            r  = axil_rsp.rresp;
            @(posedge clk_sys);
            if (ta) axil_req.arvalid <= 1'b0;
        end while (!tr);
        axil_req.rready <= 1'b0;
        check(d, ed);
        check({30'h0, r}, {30'h0, er});
    endtask

    task automatic test_reset_values;
        @(negedge clk_sys);
        check({31'h0, clk_ctrl.dcs_on}, 32'h1);
        check({31'h0, clk_ctrl.dclk_reset_enable}, 32'h0);
        check({30'h0, refclk_out_a, refclk_out_b}, 32'h0);
        rd(ADDR_COARSE, 32'h0004, RESP_OKAY);
        rd(ADDR_FINE, 32'h0000, RESP_OKAY);
        rd(ADDR_SYNC, 32'h0003, RESP_OKAY);
        rd(ADDR_RSV, 32'h000C, RESP_OKAY);
    endtask

    task automatic test_coarse_fine;
        wr(ADDR_COARSE, 32'h97F8, RESP_OKAY);
        settle();
        check({31'h0, clk_ctrl.dcs_on}, 32'h0);
        check({31'h0, clk_ctrl.aperture_adjust_on}, 32'h1);
        check({20'h0, clk_ctrl.coarse_delay_code}, 32'h97F);
        check({12'h0, clk_ctrl.aperture_delay_fs}, 32'hC96A8);
        wr(ADDR_COARSE, 32'hFFF8, RESP_OKAY);
        settle();
        check({20'h0, clk_ctrl.coarse_delay_code}, 32'h97F);
        check({12'h0, clk_ctrl.aperture_delay_fs}, 32'hC96A8);
        wr(ADDR_COARSE, 32'h3E88, RESP_OKAY);
        wr(ADDR_FINE, 32'hFC00, RESP_OKAY);
        settle();
        check({26'h0, clk_ctrl.fine_delay_code}, 32'h3F);
        check({12'h0, clk_ctrl.aperture_delay_fs}, 32'h536A2);
        wr(ADDR_COARSE, 32'h3E84, RESP_OKAY);
        settle();
        check({31'h0, clk_ctrl.aperture_adjust_on}, 32'h0);
        check({12'h0, clk_ctrl.aperture_delay_fs}, 32'h0);
        check({31'h0, clk_ctrl.dcs_on}, 32'h1);
        wr(ADDR_FINE, 32'hFF0F, RESP_OKAY);
        settle();
        check({31'h0, clk_ctrl.aperture_adjust_on}, 32'h1);
        check({31'h0, clk_ctrl.lc_filter_on}, 32'h1);
        check({12'h0, clk_ctrl.aperture_delay_fs}, 32'h536A2);
        check({21'h0, clk_ctrl.lc_center_mhz}, 32'h44C);
        rd(ADDR_FINE, 32'hFD0F, RESP_OKAY);
        wr(ADDR_COARSE, 32'hFFFF, RESP_OKAY);
        rd(ADDR_COARSE, 32'hFFFC, RESP_OKAY);
        settle();
        check({20'h0, clk_ctrl.coarse_delay_code}, 32'h97F);
    endtask

    task automatic test_lc_tuning;
        logic [31:0] wd [3];
        logic [31:0] mhz [3];
        wd  = '{32'h0100, 32'h010F, 32'h01FF};
        mhz = '{32'h5DC, 32'h44C, 32'h320};
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_FINE, wd[i], RESP_OKAY);
            settle();
            check({21'h0, clk_ctrl.lc_center_mhz}, mhz[i]);
        end
    endtask

    task automatic test_sync_fields;
        logic [31:0] wd [4];
        logic [31:0] ps [4];
        logic [31:0] deg [4];
        wd  = '{32'h0003, 32'h9FC3, 32'hFFC3, 32'hFFE3};
        ps  = '{32'h0, 32'h3E8, 32'h3E8, 32'h3E8};
        deg = '{32'h0, 32'h5A, 32'hB4, 32'h10E};
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_SYNC, wd[i], RESP_OKAY);
            settle();
            check({22'h0, clk_ctrl.ref_delay_ps}, ps[i]);
        end
        rd(ADDR_SYNC, 32'hFFC3, RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_SYNC, {27'h0, 2'(i), 3'h3}, RESP_OKAY);
            settle();
            check({23'h0, clk_ctrl.ref_phase_deg}, deg[i]);
        end
        wr(ADDR_SYNC, 32'h0007, RESP_OKAY);
        settle();
        check({31'h0, clk_ctrl.slave_mode}, 32'h1);
        wr(ADDR_SYNC, 32'h0003, RESP_OKAY);
        settle();
        check({31'h0, clk_ctrl.slave_mode}, 32'h0);
    endtask

    task automatic test_outputs_reset;
        int hi;
        int diff;
        for (int m = 0; m < 2; m++) begin
            hi = 0;
            diff = 0;
            wr(ADDR_SYNC, {29'h0, 1'(m), 2'h0}, RESP_OKAY);
            settle();
            for (int i = 0; i < 8; i++) begin
                @(negedge clk_sys);
                hi += int'(refclk_out_a);
                diff += int'(refclk_out_a !== refclk_out_b);
            end
            check(32'(hi), 32'h4);
            check(32'(diff), 32'h0);
        end
        for (int i = 0; i < 6; i++) begin
            repeat (3) @(posedge clk_sys);
            refclk_in <= ~refclk_in;
        end
        for (int v = 0; v < 2; v++) begin
            @(posedge clk_sys);
            refclk_in <= ~refclk_in;
            repeat (8) @(posedge clk_sys);
            @(negedge clk_sys);
            check({31'h0, latched_ref}, {31'h0, refclk_in});
        end
        check({31'h0, clk_ctrl.dclk_reset_enable}, 32'h1);
        @(posedge clk_sys);
        data_clock_reset_input <= 1'b1;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        check({31'h0, clk_ctrl.dclk_reset}, 32'h1);
        wr(ADDR_SYNC, 32'h0003, RESP_OKAY);
        settle();
        check({31'h0, clk_ctrl.dclk_reset}, 32'h0);
        check({30'h0, refclk_out_a, refclk_out_b}, 32'h0);
        @(posedge clk_sys);
        data_clock_reset_input <= 1'b0;
    endtask

    task automatic test_reserved_and_unmapped;
        wr(ADDR_RSV, 32'hFFFF, RESP_OKAY);
        rd(ADDR_RSV, 32'h000C, RESP_OKAY);
        wr(8'h40, 32'h1234, RESP_SLVERR);
        rd(8'h40, 32'h0, RESP_SLVERR);
    endtask

    initial begin
        int cycles;
        cycles = 0;
        while (cycles < 20000) begin
            @(posedge clk_sys);
            cycles++;
        end
        miscompares++;
        finish_test();
    end

    initial begin
        miscompares = 0;
        n_tests = 0;
        rst = 1'b1;
        refclk_in = 1'b0;
        data_clock_reset_input = 1'b0;
        axil_req = '0;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        test_reset_values();
        test_coarse_fine();
        test_lc_tuning();
        test_sync_fields();
        test_outputs_reset();
        test_reserved_and_unmapped();
        finish_test();
    end
endmodule
